/* spf_pkg.sv */
// package: register map, command codes and timing for self-program flash control
package spf_pkg;
  // apb register byte offsets
  localparam logic [7:0] SPF_OFS_CTRL   = 8'h00;
  localparam logic [7:0] SPF_OFS_DATA   = 8'h04;
  localparam logic [7:0] SPF_OFS_ADDR   = 8'h08;
  localparam logic [7:0] SPF_OFS_STATUS = 8'h0C;
  localparam logic [7:0] SPF_OFS_NVM    = 8'h10;

  // control register fields
  localparam int SPF_B_EN    = 0;
  localparam int SPF_B_ERS   = 1;
  localparam int SPF_B_WRT   = 2;
  localparam int SPF_B_FLRD  = 3;
  localparam int SPF_B_CLR   = 4;
  localparam int SPF_B_SIGNATURE_READ_CMD = 5;
  localparam logic [7:0] SPF_CTRL_RESET = 8'h00;

  // permitted command patterns, low six bits
  localparam logic [5:0] SPF_CMD_SIG   = 6'h21;
  localparam logic [5:0] SPF_CMD_CLR   = 6'h11;
  localparam logic [5:0] SPF_CMD_FLRD  = 6'h09;
  localparam logic [5:0] SPF_CMD_WRT   = 6'h05;
  localparam logic [5:0] SPF_CMD_ERS   = 6'h03;
  localparam logic [5:0] SPF_CMD_LOAD  = 6'h01;

  // command windows in clock cycles
  localparam logic [2:0] SPF_STORE_WIN = 3'h4;
  localparam logic [2:0] SPF_LOAD_WIN  = 3'h3;

  // fuse/lock read pointer addresses
  localparam logic [15:0] SPF_Z_FUSE_LO = 16'h0000;
  localparam logic [15:0] SPF_Z_LOCK    = 16'h0001;
  localparam logic [15:0] SPF_Z_EFUSE   = 16'h0002;
  localparam logic [15:0] SPF_Z_FUSE_HI = 16'h0003;

  // signature row pointer addresses
  localparam logic [15:0] SPF_Z_SIG0  = 16'h0000;
  localparam logic [15:0] SPF_Z_CAL   = 16'h0001;
  localparam logic [15:0] SPF_Z_SIG1  = 16'h0002;
  localparam logic [15:0] SPF_Z_SIG2  = 16'h0004;
  localparam logic [15:0] SPF_Z_TSOFS = 16'h0005;
  localparam logic [15:0] SPF_Z_TSGN  = 16'h0007;

  // programming time, microseconds, and clock rate
  localparam int SPF_CLK_MHZ     = 50;
  localparam int SPF_PROG_MIN_US = 3700;
  localparam int SPF_PROG_MAX_US = 4500;
  localparam int SPF_PROG_CYCLES = SPF_PROG_MIN_US * SPF_CLK_MHZ;

  // fixed field masks
  localparam logic [7:0] SPF_LOCK_MASK  = 8'h03;
  localparam logic [7:0] SPF_EFUSE_MASK = 8'h01;

  typedef enum logic [1:0] {
    SPF_IDLE  = 2'b00,
    SPF_ERASE = 2'b01,
    SPF_WRITE = 2'b10
  } spf_op_e;
endpackage

/* spf_page_buf.sv */
// temporary page buffer with load-once tracking
`timescale 1ns/1ps
module spf_page_buf
  import spf_pkg::*;
#(
  parameter int WORDS = 32,
  parameter int AW    = 5
) (
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // control
  input  wire logic          clear,
  input  wire logic          load,
  input  wire logic [AW-1:0] load_idx,
  input  wire logic [15:0]   load_data,
  // readback for page programming
  input  wire logic [AW-1:0] rd_idx,
  output logic      [15:0]   rd_data,
  output logic               rd_valid
);
  logic [15:0]      mem [WORDS];
  logic [WORDS-1:0] filled;

  genvar g;
  generate
    for (g = 0; g < WORDS; g++) begin : g_word
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mem[g] <= 16'h0000;
        end else if (clear) begin
          mem[g] <= 16'hFFFF;
        end else if (load && load_idx == AW'(g) && !filled[g]) begin
          mem[g] <= load_data;
        end
      end
    end
  endgenerate

  // second load to a word is dropped until the next clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filled <= '0;
    end else if (clear) begin
      filled <= '0;
    end else if (load) begin
      filled[load_idx] <= 1'b1;
    end
  end

  assign rd_data  = filled[rd_idx] ? mem[rd_idx] : 16'hFFFF;
  assign rd_valid = filled[rd_idx];
endmodule

/* spf_op_timer.sv */
// programming-time counter for erase and write
`timescale 1ns/1ps
module spf_op_timer #(
  parameter int CYCLES = 185000
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  logic [31:0] cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt  <= 32'h0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        cnt  <= 32'(CYCLES - 1);
        busy <= 1'b1;
      end else if (busy) begin
        if (cnt == 32'h0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt <= cnt - 32'h1;
        end
      end
    end
  end
endmodule

/* spf_ctrl.sv */
// self-program flash control: apb registers, command windows, erase/write sequencing
// Summary of operation
// - pointer high bits page, low bits word
// - load reads bytes, pointer bit0 picks byte
// - enable arms store four cycles, self-clears
// - plain enable: store loads buffer word
// - erase command erases pointer page, halts CPU
// - write command programs buffer into page
// - enable stays high while erase/write busy
// - clear command empties the page buffer
// - only six command patterns act
// - signature read via load within three cycles
// - signature bits clear after read/timeout
// - fuse/lock read selects byte by pointer
// - fuse/lock bits clear after read/timeouts
// - programmed reads zero; lock/efuse masks
// - eeprom write blocks commands and fuse/lock reads
// - signature row address map
// - bits 6 and 7 read zero
// - buffer erased after write and reset
// - erase/write take 3.7 to 4.5 ms
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
module spf_ctrl
  import spf_pkg::*;
#(
  parameter int PAGE_WORDS  = 32,
  parameter int WORD_BITS   = 5,
  parameter int PAGE_BITS   = 8,
  parameter int PROG_CYCLES = SPF_PROG_CYCLES,
  parameter logic [7:0] SIG0  = 8'h1E, // arbitrary identification value
  parameter logic [7:0] SIG1  = 8'h55, // arbitrary identification value
  parameter logic [7:0] SIG2  = 8'hAA  // arbitrary identification value
) (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // cpu instruction strobes, same clock
  input  wire logic        store_instr,
  input  wire logic        load_program_instr,
  input  wire logic [15:0] pointer,
  input  wire logic [15:0] operand_register_pair,
  input  wire logic        eeprom_write_busy,
  // non-volatile values
  input  wire logic [7:0]  fuse_low_byte,
  input  wire logic [7:0]  fuse_high_byte,
  input  wire logic [7:0]  extended_fuse_byte,
  input  wire logic [1:0]  lock_bits,
  input  wire logic [7:0]  osc_cal_byte,
  input  wire logic [7:0]  temp_sensor_offset_byte,
  input  wire logic [7:0]  temp_sensor_gain_byte,
  // results
  output logic             load_valid,
  output logic      [7:0]  load_data,
  output logic             flash_read_req,
  output logic             cpu_halt,
  output logic             flash_erase,
  output logic             flash_write,
  output logic [PAGE_BITS-1:0] page_select_field
);
  logic [7:0]  ctrl;
  logic [2:0]  win;
  spf_op_e     op;
  logic        t_busy;
  logic        t_done;
  logic        t_start;
  logic        buf_clear;
  logic        buf_load;
  logic [15:0] buf_rd;
  logic        buf_rdv;
  logic        wr_en;
  logic        reg_wr;
  logic [5:0]  cmd;

  function automatic logic cmd_ok(input logic [5:0] c);
    return c == SPF_CMD_SIG || c == SPF_CMD_CLR || c == SPF_CMD_FLRD
        || c == SPF_CMD_WRT || c == SPF_CMD_ERS || c == SPF_CMD_LOAD;
  endfunction

  function automatic logic [WORD_BITS-1:0] word_of(input logic [15:0] z);
    return z[WORD_BITS:1];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  assign wr_en  = psel && penable && pwrite;
  assign reg_wr = wr_en && paddr == SPF_OFS_CTRL;
  assign cmd    = pwdata[5:0];

  wire logic armed     = ctrl[SPF_B_EN] && op == SPF_IDLE;
  wire logic is_sig    = armed && ctrl[SPF_B_SIGNATURE_READ_CMD];
  wire logic is_flrd   = armed && ctrl[SPF_B_FLRD];
  wire logic store_hit = armed && store_instr && win != 3'h0;
  wire logic load_sp   = (is_sig || is_flrd) && load_program_instr && win != 3'h0
                         && win > SPF_STORE_WIN - SPF_LOAD_WIN;

  // command register and windows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= SPF_CTRL_RESET;
      win  <= 3'h0;
    end else if (reg_wr && op == SPF_IDLE && cmd_ok(cmd) && !eeprom_write_busy) begin
      ctrl <= {2'b00, cmd};
      win  <= SPF_STORE_WIN;
    end else if (op != SPF_IDLE) begin
      if (t_done) begin
        ctrl <= SPF_CTRL_RESET;
      end
      // enable held as busy flag meanwhile
    end else if (store_hit && !ctrl[SPF_B_ERS] && !ctrl[SPF_B_WRT]) begin
      ctrl <= SPF_CTRL_RESET;
      win  <= 3'h0;
    end else if (load_sp) begin
      ctrl <= SPF_CTRL_RESET;
      win  <= 3'h0;
    end else if (ctrl[SPF_B_EN] && !t_start) begin
      // an erase/write store refused while eeprom is busy must still let the window run out
      if (win == 3'h1) begin
        ctrl <= SPF_CTRL_RESET;
      end
      win <= (win == 3'h0) ? 3'h0 : win - 3'h1;
    end
  end

  // read windows close after three cycles
  wire logic ld_win_dead = ctrl[SPF_B_SIGNATURE_READ_CMD] && win <= SPF_STORE_WIN - SPF_LOAD_WIN;

  ////////////////////////////////////////////////////////////////////////
  // erase/write sequencing
  assign t_start = store_hit && (ctrl[SPF_B_ERS] || ctrl[SPF_B_WRT]) && !eeprom_write_busy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op                <= SPF_IDLE;
      cpu_halt          <= 1'b0;
      flash_erase       <= 1'b0;
      flash_write       <= 1'b0;
      page_select_field <= '0;
    end else begin
      unique case (op)
        SPF_IDLE: begin
          if (t_start) begin
            op                <= ctrl[SPF_B_ERS] ? SPF_ERASE : SPF_WRITE;
            cpu_halt          <= 1'b1;
            flash_erase       <= ctrl[SPF_B_ERS];
            flash_write       <= ctrl[SPF_B_WRT];
            page_select_field <= pointer[WORD_BITS+PAGE_BITS:WORD_BITS+1];
          end
        end
        SPF_ERASE, SPF_WRITE: begin
          if (t_done) begin
            op          <= SPF_IDLE;
            cpu_halt    <= 1'b0;
            flash_erase <= 1'b0;
            flash_write <= 1'b0;
          end
        end
        default: op <= SPF_IDLE;
      endcase
    end
  end

  spf_op_timer #(.CYCLES(PROG_CYCLES)) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (t_start),
    .busy    (t_busy),
    .done    (t_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // page buffer
  assign buf_load  = store_hit && ctrl[5:0] == SPF_CMD_LOAD && !eeprom_write_busy;
  assign buf_clear = (store_hit && ctrl[5:0] == SPF_CMD_CLR && !eeprom_write_busy)
                     || (op == SPF_WRITE && t_done);

  spf_page_buf #(.WORDS(PAGE_WORDS), .AW(WORD_BITS)) u_buf (
    .pclk      (pclk),
    .presetn   (presetn),
    .clear     (buf_clear),
    .load      (buf_load),
    .load_idx  (word_of(pointer)),
    .load_data (operand_register_pair),
    .rd_idx    (word_of(pointer)),
    .rd_data   (buf_rd),
    .rd_valid  (buf_rdv)
  );

  ////////////////////////////////////////////////////////////////////////
  // special loads: signature row and fuse/lock bytes
  function automatic logic [7:0] sig_byte(input logic [15:0] z);
    unique case (z)
      SPF_Z_SIG0:  return SIG0;
      SPF_Z_SIG1:  return SIG1;
      SPF_Z_SIG2:  return SIG2;
      SPF_Z_CAL:   return osc_cal_byte;
      SPF_Z_TSOFS: return temp_sensor_offset_byte;
      SPF_Z_TSGN:  return temp_sensor_gain_byte;
      default:     return 8'hFF;
    endcase
  endfunction

  function automatic logic [7:0] fuse_byte(input logic [15:0] z);
    unique case (z)
      SPF_Z_LOCK:    return {6'h3F, lock_bits} | ~SPF_LOCK_MASK;
      SPF_Z_FUSE_LO: return fuse_low_byte;
      SPF_Z_FUSE_HI: return fuse_high_byte;
      SPF_Z_EFUSE:   return extended_fuse_byte | ~SPF_EFUSE_MASK;
      default:       return 8'hFF;
    endcase
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_valid     <= 1'b0;
      load_data      <= 8'h00;
      flash_read_req <= 1'b0;
    end else begin
      load_valid     <= 1'b0;
      flash_read_req <= 1'b0;
      if (load_sp && is_sig) begin
        load_valid <= 1'b1;
        load_data  <= sig_byte(pointer);
      end else if (load_sp && is_flrd && !eeprom_write_busy) begin
        load_valid <= 1'b1;
        load_data  <= fuse_byte(pointer);
      end else if (load_program_instr && !load_sp) begin
        // ordinary byte read handed to the array, bit0 picks the byte
        flash_read_req <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb read side; zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        unique case (paddr)
          SPF_OFS_CTRL:   prdata <= {24'h0, 2'b00, ctrl[5:0]};
          SPF_OFS_DATA:   prdata <= {16'h0, buf_rd};
          SPF_OFS_ADDR:   prdata <= {16'h0, pointer};
          SPF_OFS_STATUS: prdata <= {28'h0, buf_rdv, t_busy, cpu_halt, ld_win_dead};
          SPF_OFS_NVM:    prdata <= {24'h0, load_data};
          default: begin
            prdata  <= 32'h0;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // pready pulses with penable: one-cycle access
  sequence s_load_armed;
    reg_wr && op == SPF_IDLE && cmd == SPF_CMD_LOAD && !eeprom_write_busy;
  endsequence

  sequence s_no_store;
    (!store_instr)[*4];
  endsequence

  AST_EN_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
    op != SPF_IDLE |-> ctrl[SPF_B_EN]) else $error("enable dropped while busy");
  AST_HALT: assert property (@(posedge pclk) disable iff (!presetn)
    t_start |=> cpu_halt) else $error("halt not raised");
  AST_TOP_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl[7:6] == 2'b00) else $error("top bits set");
  AST_STORE_TIMEOUT: assert property (@(posedge pclk) disable iff (!presetn)
    s_load_armed ##1 s_no_store |=> !ctrl[SPF_B_EN]) else $error("window not closed");
  AST_BAD_CMD: assert property (@(posedge pclk) disable iff (!presetn)
    (reg_wr && !cmd_ok(cmd) && !ctrl[SPF_B_EN]) |=> !ctrl[SPF_B_EN])
    else $error("illegal pattern acted");
  AST_EE_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
    (reg_wr && eeprom_write_busy && !ctrl[SPF_B_EN]) |=> !ctrl[SPF_B_EN])
    else $error("eeprom busy not honoured");
  AST_DONE_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    (op != SPF_IDLE && t_done) |=> ctrl == SPF_CTRL_RESET && !cpu_halt)
    else $error("completion not cleared");
  AST_SIG_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    (load_sp && is_sig) |=> load_valid ##0 ctrl == SPF_CTRL_RESET)
    else $error("signature read missing");
  AST_FLRD_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    (load_sp && is_flrd && !eeprom_write_busy && !reg_wr) |=> load_valid && !ctrl[SPF_B_EN])
    else $error("fuse read missing");
  AST_PLAIN_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    (load_program_instr && !load_sp) |=> flash_read_req) else $error("plain load lost");
  AST_OP_KIND: assert property (@(posedge pclk) disable iff (!presetn)
    t_start |=> flash_erase != flash_write) else $error("operation kind wrong");
  AST_BUF_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    (op == SPF_WRITE && t_done) |=> !buf_rdv) else $error("buffer kept after write");
endmodule

/* spf_cpu_model.sv */
// cpu core model: issues program-memory store and load instructions
`timescale 1ns/1ps
module spf_cpu_model
  import spf_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // answers from the flash control
  input  wire logic        cpu_halt,
  input  wire logic        load_valid,
  input  wire logic [7:0]  load_data,
  input  wire logic        flash_read_req,
  // instruction strobes and registers
  output logic             store_instr,
  output logic             load_program_instr,
  output logic      [15:0] pointer,
  output logic      [15:0] operand_register_pair
);
  int         halt_cnt = 0;
  int         spec_cnt = 0;
  int         rd_cnt   = 0;
  logic [7:0] cap_byte = 8'h00;

  initial begin
    store_instr           = 1'b0;
    load_program_instr    = 1'b0;
    pointer               = 16'h0000;
    operand_register_pair = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // halted core issues nothing; one store at a time
  task automatic issue(input logic st, input int dly, input logic [15:0] p, input logic [15:0] d);
    while (cpu_halt !== 1'b0) begin
      @(posedge pclk);
    end
    for (int i = 0; i < dly; i++) begin
      @(posedge pclk);
    end
    pointer               <= p;
    operand_register_pair <= d;
    store_instr           <= st;
    load_program_instr    <= !st;
    @(posedge pclk);
    store_instr        <= 1'b0;
    load_program_instr <= 1'b0;
  endtask

  task automatic set_ptr(input logic [15:0] p);
    pointer <= p;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    if (cpu_halt === 1'b1) halt_cnt++;
    if (flash_read_req === 1'b1) rd_cnt++;
    if (load_valid === 1'b1) begin
      spec_cnt++;
      cap_byte = load_data;
    end
  end
endmodule

/* spf_ctrl_tb.sv */
// testbench for self-program flash control
`timescale 1ns/1ps
module spf_ctrl_tb import spf_pkg::*;;
  localparam int PROG = 20;
  localparam logic [7:0] S0 = 8'h3C; // arbitrary identification value
  localparam logic [7:0] S1 = 8'h5A; // arbitrary identification value
  localparam logic [7:0] S2 = 8'hC3; // arbitrary identification value

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ee_busy;
  logic [7:0]  paddr, load_data, page_sel;
  logic [31:0] pwdata, prdata, rdat;
  logic        rerr, load_valid, flash_read_req, cpu_halt, flash_erase, flash_write;
  logic        store_instr, lpi;
  logic [15:0] pointer, opnd;
  logic [7:0]  nv [7];
  logic [1:0]  lock;
  logic [15:0] fz [4];
  logic [7:0]  fm [4];
  logic [15:0] sz [6];
  logic [7:0]  se [6];
  logic [7:0]  bad [3];
  int          error_cnt, n_checks, cyc, k, s, h;

  spf_ctrl #(.PROG_CYCLES(PROG), .SIG0(S0), .SIG1(S1), .SIG2(S2)) u_spf_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .store_instr(store_instr), .load_program_instr(lpi), .pointer(pointer),
    .operand_register_pair(opnd), .eeprom_write_busy(ee_busy),
    .fuse_low_byte(nv[0]), .fuse_high_byte(nv[1]), .extended_fuse_byte(nv[2]),
    .lock_bits(lock), .osc_cal_byte(nv[3]), .temp_sensor_offset_byte(nv[4]),
    .temp_sensor_gain_byte(nv[5]), .load_valid(load_valid), .load_data(load_data),
    .flash_read_req(flash_read_req), .cpu_halt(cpu_halt), .flash_erase(flash_erase),
    .flash_write(flash_write), .page_select_field(page_sel));

  spf_cpu_model u_spf_cpu_model (
    .pclk(pclk), .presetn(presetn), .cpu_halt(cpu_halt), .load_valid(load_valid),
    .load_data(load_data), .flash_read_req(flash_read_req), .store_instr(store_instr),
    .load_program_instr(lpi), .pointer(pointer), .operand_register_pair(opnd));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] cmd);
    apb(1'b1, SPF_OFS_CTRL, {24'h0, cmd});
  endtask

  task automatic rctl(input logic [7:0] exp);
    apb(1'b0, SPF_OFS_CTRL, 32'h0);
    check(rdat, {24'h0, exp});
  endtask

  task automatic rdb(input logic [15:0] p, input logic [15:0] exp);
    u_spf_cpu_model.set_ptr(p);
    apb(1'b0, SPF_OFS_DATA, 32'h0);
    check(rdat[15:0], exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; ee_busy = 1'b0; lock = 2'b10;
    nv = '{8'h62, 8'hD9, 8'h7E, 8'h91, 8'h4B, 8'hB6, 8'h00};
    fz = '{16'h0000, 16'h0001, 16'h0002, 16'h0003};
    fm = '{8'hFF, 8'h03, 8'h01, 8'hFF};
    sz = '{16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'h0005, 16'h0007};
    se = '{S0, 8'h91, S1, S2, 8'h4B, 8'hB6};
    bad = '{8'h07, 8'h3F, 8'h23};
    error_cnt = 0; n_checks = 0; cyc = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rctl(8'h00);
    apb(1'b0, 8'h14, 32'h0);
    check(rerr, 1); check(rdat, 0);
    rdb(16'h0042, 16'hFFFF);
    wr(8'h01); u_spf_cpu_model.issue(1, 3, 16'h0043, 16'hA5C3);
    rdb(16'h0042, 16'hA5C3);
    rctl(8'h00);
    wr(8'h01); u_spf_cpu_model.issue(1, 0, 16'h0042, 16'h1111);
    rdb(16'h0042, 16'hA5C3);
    wr(8'h01); u_spf_cpu_model.issue(1, 4, 16'h0044, 16'h2222);
    rdb(16'h0044, 16'hFFFF);
    foreach (bad[i]) begin
      wr(bad[i]); rctl(8'h00);
    end
    ee_busy <= 1'b1;
    wr(8'h11); rctl(8'h00);
    rdb(16'h0042, 16'hA5C3);
    ee_busy <= 1'b0;
    wr(8'h11); u_spf_cpu_model.issue(1, 0, 16'h0042, 16'h0);
    rdb(16'h0042, 16'hFFFF);
    for (int i = 0; i < 4; i++) begin
      s = u_spf_cpu_model.spec_cnt;
      wr(8'h09); u_spf_cpu_model.issue(0, 2, fz[i], 16'h0);
      repeat (2) @(posedge pclk);
      check(u_spf_cpu_model.cap_byte & fm[i], (i == 1 ? {6'h0, lock} : nv[i == 3 ? 1 : (i == 2 ? 2 : 0)]) & fm[i]);
      check(u_spf_cpu_model.spec_cnt, s + 1);
    end
    for (int i = 0; i < 6; i++) begin
      s = u_spf_cpu_model.spec_cnt;
      wr(8'h21); u_spf_cpu_model.issue(0, 0, sz[i], 16'h0);
      repeat (2) @(posedge pclk);
      check(u_spf_cpu_model.cap_byte, se[i]);
      check(u_spf_cpu_model.spec_cnt, s + 1);
    end
    rctl(8'h00);
    for (int i = 0; i < 2; i++) begin
      k = u_spf_cpu_model.rd_cnt; s = u_spf_cpu_model.spec_cnt;
      wr(i == 0 ? 8'h09 : 8'h21); u_spf_cpu_model.issue(0, 3, 16'h0, 16'h0);
      repeat (2) @(posedge pclk);
      check(u_spf_cpu_model.rd_cnt, k + 1);
      check(u_spf_cpu_model.spec_cnt, s);
    end
    wr(8'h21); u_spf_cpu_model.issue(1, 0, 16'h0042, 16'h3333);
    rdb(16'h0042, 16'hFFFF);
    wr(8'h01); u_spf_cpu_model.issue(1, 0, 16'h1A42, 16'h1234);
    for (int i = 0; i < 2; i++) begin
      h = u_spf_cpu_model.halt_cnt;
      wr(i == 0 ? 8'h03 : 8'h05); u_spf_cpu_model.issue(1, 0, 16'h1A40, 16'h0);
      @(posedge pclk);
      check(cpu_halt, 1);
      check(i == 0 ? flash_erase : flash_write, 1);
      check(page_sel, 8'h69);
      rctl(i == 0 ? 8'h03 : 8'h05);
      k = 0;
      while (cpu_halt !== 1'b0 && k < 200) begin
        @(posedge pclk);
        k++;
      end
      check(k < 200, 1);
      rctl(8'h00);
      h = u_spf_cpu_model.halt_cnt - h;
      check(h >= PROG && h <= PROG + 2, 1);
      rdb(16'h1A42, i == 0 ? 16'h1234 : 16'hFFFF);
    end
    finish_test();
  end
endmodule
